/* pkg/aux_result_pkg.sv */
// Purpose: Shared constants and types for the aux converter result bank
// Assumes: 16-bit registers at byte offsets, plain strobe register port
// Notes: Offsets are byte addresses of 16-bit words; 12 address bits
package aux_result_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int SAMPLE_W = 15;
  localparam int LOWBAT_W = 12;
  localparam int RAW_W = 17;
  localparam int READY_BIT = 15;
  localparam int NUM_SLOTS = 11;

  localparam logic [11:0] OFS_BATTERY_VOLTAGE = 12'h714;
  localparam logic [11:0] OFS_CURRENT_SENSE = 12'h716;
  localparam logic [11:0] OFS_CHARGER_DETECT = 12'h718;
  localparam logic [11:0] OFS_BATTERY_ID_ONE = 12'h71a;
  localparam logic [11:0] OFS_THERMAL_ONE = 12'h71c;
  localparam logic [11:0] OFS_THERMAL_TWO = 12'h71e;
  localparam logic [11:0] OFS_BATTERY_ID_TWO = 12'h720;
  localparam logic [11:0] OFS_CHANNEL_FIVE = 12'h722;
  localparam logic [11:0] OFS_PRECHARGER_WAKE = 12'h724;
  localparam logic [11:0] OFS_SWITCH_CHARGER_WAKE = 12'h726;
  localparam logic [11:0] OFS_LOW_BATTERY = 12'h728;
  localparam logic [11:0] OFS_CHANNEL_SIX = 12'h72a;
  localparam logic [11:0] OFS_GPS_READY = 12'h72c;
  localparam logic [11:0] OFS_GPS_MAIN = 12'h72e;
  localparam logic [11:0] OFS_GPS_EXTRA = 12'h730;
  localparam logic [11:0] OFS_MODEM_CH7 = 12'h732;
  localparam logic [11:0] OFS_RAW_UPPER = 12'h738;
  localparam logic [11:0] OFS_RAW_BUSY = 12'h73a;

  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Slot order of the ready-flagged 15-bit results
  typedef enum logic [3:0] {
    SLOT_BATTERY_VOLTAGE = 4'h0,
    SLOT_CURRENT_SENSE = 4'h1,
    SLOT_CHARGER_DETECT = 4'h2,
    SLOT_BATTERY_ID_ONE = 4'h3,
    SLOT_THERMAL_ONE = 4'h4,
    SLOT_THERMAL_TWO = 4'h5,
    SLOT_BATTERY_ID_TWO = 4'h6,
    SLOT_CHANNEL_FIVE = 4'h7,
    SLOT_PRECHARGER_WAKE = 4'h8,
    SLOT_SWITCH_CHARGER_WAKE = 4'h9,
    SLOT_CHANNEL_SIX = 4'ha
  } slot_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic busy;
    logic [RAW_W-1:0] raw;
  } raw_filter_type;

  typedef struct packed {
    logic ready;
    logic [SAMPLE_W-1:0] sample;
  } result_word_type;

endpackage

/* src/aux_result_slot.sv */
// Purpose: One ready flag plus sample, updated as a single unit
// Assumes: start and done pulses come from converter logic on clk_sys_i
// Notes: Start clears ready; done loads sample and sets ready together
`timescale 1ns/1ps
`default_nettype none
module aux_result_slot
  import aux_result_pkg::*;
#(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Converter side
  input wire logic start_i,
  input wire logic done_i,
  input wire logic [WIDTH-1:0] sample_i,
  // Result
  output logic ready_o,
  output logic [WIDTH-1:0] sample_o
);

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b0;
      sample_o <= '0;
    end else if (ce_i) begin
      if (done_i) begin
        // Flag and value move in the same edge; done beats start
        ready_o <= 1'b1;
        sample_o <= sample_i;
      end else if (start_i) begin
        ready_o <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* src/aux_result_read_mux.sv */
// Purpose: Address decode and registered read data for the result bank
// Assumes: Read data is valid only in the cycle after the read strobe
// Notes: Unmapped addresses read as zero; writes have no effect
`timescale 1ns/1ps
`default_nettype none
module aux_result_read_mux
  import aux_result_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register request
  input wire reg_req_type req_i,
  // Word sources
  input wire logic [NUM_SLOTS*DATA_W-1:0] slot_words_i,
  input wire logic [DATA_W-1:0] low_battery_word_i,
  input wire logic [DATA_W-1:0] gps_ready_word_i,
  input wire logic [DATA_W-1:0] gps_main_word_i,
  input wire logic [DATA_W-1:0] gps_extra_word_i,
  input wire logic [DATA_W-1:0] modem_word_i,
  input wire logic [DATA_W-1:0] raw_upper_word_i,
  input wire logic [DATA_W-1:0] raw_busy_word_i,
  // Read data
  output logic [DATA_W-1:0] rdata_o
);

  function automatic logic [DATA_W-1:0] slot_word(
    input logic [NUM_SLOTS*DATA_W-1:0] words,
    input slot_type s
  );
    slot_word = words[int'(s)*DATA_W +: DATA_W];
  endfunction

  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    unique case (req_i.addr)
      OFS_BATTERY_VOLTAGE: rdata_nxt = slot_word(slot_words_i,
        SLOT_BATTERY_VOLTAGE);
      OFS_CURRENT_SENSE: rdata_nxt = slot_word(slot_words_i,
        SLOT_CURRENT_SENSE);
      OFS_CHARGER_DETECT: rdata_nxt = slot_word(slot_words_i,
        SLOT_CHARGER_DETECT);
      OFS_BATTERY_ID_ONE: rdata_nxt = slot_word(slot_words_i,
        SLOT_BATTERY_ID_ONE);
      OFS_THERMAL_ONE: rdata_nxt = slot_word(slot_words_i,
        SLOT_THERMAL_ONE);
      OFS_THERMAL_TWO: rdata_nxt = slot_word(slot_words_i,
        SLOT_THERMAL_TWO);
      OFS_BATTERY_ID_TWO: rdata_nxt = slot_word(slot_words_i,
        SLOT_BATTERY_ID_TWO);
      OFS_CHANNEL_FIVE: rdata_nxt = slot_word(slot_words_i,
        SLOT_CHANNEL_FIVE);
      OFS_PRECHARGER_WAKE: rdata_nxt = slot_word(slot_words_i,
        SLOT_PRECHARGER_WAKE);
      OFS_SWITCH_CHARGER_WAKE: rdata_nxt = slot_word(slot_words_i,
        SLOT_SWITCH_CHARGER_WAKE);
      OFS_CHANNEL_SIX: rdata_nxt = slot_word(slot_words_i,
        SLOT_CHANNEL_SIX);
      OFS_LOW_BATTERY: rdata_nxt = low_battery_word_i;
      OFS_GPS_READY: rdata_nxt = gps_ready_word_i;
      OFS_GPS_MAIN: rdata_nxt = gps_main_word_i;
      OFS_GPS_EXTRA: rdata_nxt = gps_extra_word_i;
      OFS_MODEM_CH7: rdata_nxt = modem_word_i;
      OFS_RAW_UPPER: rdata_nxt = raw_upper_word_i;
      OFS_RAW_BUSY: rdata_nxt = raw_busy_word_i;
      default: rdata_nxt = RESULT_RESET;
    endcase
  end

  // Reads only sample; nothing in the bank reacts to a read
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= RESULT_RESET;
    end else if (ce_i) begin
      rdata_o <= req_i.rd ? rdata_nxt : RESULT_RESET;
    end
  end

endmodule
`default_nettype wire

/* src/aux_result_bank.sv */
// Purpose: Read-only result register bank of the aux measure converter
// Assumes: Converter strobes are synchronous to clk_sys_i; raw filter
//   data and busy are synchronous too
// Notes: Every word resets to zero and ignores writes
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module aux_result_bank
  import aux_result_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Flagged channel results, one bit or one 15-bit sample per slot_type entry
  input wire logic [NUM_SLOTS-1:0] slot_start_i,
  input wire logic [NUM_SLOTS-1:0] slot_done_i,
  input wire logic [NUM_SLOTS*SAMPLE_W-1:0] slot_sample_i,
  // Low battery measure
  input wire logic low_battery_start_i,
  input wire logic low_battery_done_i,
  input wire logic [LOWBAT_W-1:0] low_battery_sample_i,
  // GPS channel seven
  input wire logic gps_start_i,
  input wire logic gps_done_i,
  input wire logic [DATA_W:0] gps_sample_i,
  // Modem channel seven
  input wire logic modem_done_i,
  input wire logic [DATA_W-1:0] modem_sample_i,
  // Raw decimation filter
  input wire raw_filter_type raw_filter_i
);

  // ------------------------------------------------------------
  // Flagged 15-bit results
  // ------------------------------------------------------------
  logic [NUM_SLOTS*DATA_W-1:0] slot_words;

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    logic rdy;
    logic [SAMPLE_W-1:0] smp;
    aux_result_slot #(.WIDTH(SAMPLE_W)) u_slot (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .start_i(slot_start_i[g]),
      .done_i(slot_done_i[g]),
      .sample_i(slot_sample_i[g*SAMPLE_W +: SAMPLE_W]),
      .ready_o(rdy),
      .sample_o(smp)
    );
    assign slot_words[g*DATA_W +: DATA_W] = {rdy, smp};
  end

  // ------------------------------------------------------------
  // Low battery, 12 bits
  // ------------------------------------------------------------
  logic low_battery_ready;
  logic [LOWBAT_W-1:0] low_battery_value;

  aux_result_slot #(.WIDTH(LOWBAT_W)) u_low_battery (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(low_battery_start_i),
    .done_i(low_battery_done_i),
    .sample_i(low_battery_sample_i),
    .ready_o(low_battery_ready),
    .sample_o(low_battery_value)
  );

  // ------------------------------------------------------------
  // GPS result: 16-bit main value plus one extra low bit
  // ------------------------------------------------------------
  logic gps_ready;
  logic [DATA_W:0] gps_value;

  aux_result_slot #(.WIDTH(DATA_W + 1)) u_gps (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(gps_start_i),
    .done_i(gps_done_i),
    .sample_i(gps_sample_i),
    .ready_o(gps_ready),
    .sample_o(gps_value)
  );

  // ------------------------------------------------------------
  // Modem value and raw filter capture
  // ------------------------------------------------------------
  logic [DATA_W-1:0] modem_value_r;
  raw_filter_type raw_filter_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      modem_value_r <= RESULT_RESET;
    end else if (ce_i && modem_done_i) begin
      modem_value_r <= modem_sample_i;
    end
  end

  // Registered so busy and raw bit 0 are seen from one edge
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw_filter_r <= '0;
    end else if (ce_i) begin
      raw_filter_r <= raw_filter_i;
    end
  end

  // ------------------------------------------------------------
  // Register port; wdata and wr are accepted and dropped
  // ------------------------------------------------------------
  reg_req_type req;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  aux_result_read_mux u_read (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .req_i(req),
    .slot_words_i(slot_words),
    .low_battery_word_i({low_battery_ready, 3'h0, low_battery_value}),
    .gps_ready_word_i({gps_ready, 15'h0000}),
    .gps_main_word_i(gps_value[DATA_W:1]),
    .gps_extra_word_i({gps_value[0], 15'h0000}),
    .modem_word_i(modem_value_r),
    .raw_upper_word_i(raw_filter_r.raw[RAW_W-1:1]),
    .raw_busy_word_i({{15{raw_filter_r.busy}}, raw_filter_r.raw[0]}),
    .rdata_o(rdata_o)
  );

endmodule
`default_nettype wire

/* verif/aux_result_bank_asserts.sv */
// Purpose: Port-level checks on the aux converter result bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Slot checks watch slot 0; the bench reads the others
`timescale 1ns/1ps
`default_nettype none
module aux_result_bank_asserts
  import aux_result_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // Converter side
  input wire logic [NUM_SLOTS-1:0] slot_start_i,
  input wire logic [NUM_SLOTS-1:0] slot_done_i,
  input wire logic [NUM_SLOTS*SAMPLE_W-1:0] slot_sample_i,
  input wire logic gps_start_i,
  input wire logic gps_done_i,
  input wire logic [DATA_W:0] gps_sample_i,
  input wire logic modem_done_i,
  input wire logic [DATA_W-1:0] modem_sample_i,
  input wire raw_filter_type raw_filter_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic rd_en;
  assign rd_en = rd_i && ce_i;
  property p_idle_zero;
    ce_i && !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero outside a read");
  property p_frozen;
    !ce_i |=> $stable(rdata_o);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("read data moved while disabled");
  property p_raw_upper;
    rd_en && $past(ce_i) && addr_i == OFS_RAW_UPPER
      |=> rdata_o == $past(raw_filter_i.raw[16:1], 2);
  endproperty
  a_raw_upper: assert property (p_raw_upper)
    else $error("raw upper word wrong");
  property p_raw_busy;
    rd_en && $past(ce_i) && addr_i == OFS_RAW_BUSY |=> rdata_o ==
      {{15{$past(raw_filter_i.busy, 2)}}, $past(raw_filter_i.raw[0], 2)};
  endproperty
  a_raw_busy: assert property (p_raw_busy)
    else $error("raw busy word wrong");
  property p_modem_load;
    modem_done_i && ce_i ##1 rd_en && addr_i == OFS_MODEM_CH7 &&
      !modem_done_i |=> rdata_o == $past(modem_sample_i, 2);
  endproperty
  a_modem_load: assert property (p_modem_load)
    else $error("modem word wrong after load");
  property p_gps_main;
    gps_done_i && ce_i ##1 rd_en && addr_i == OFS_GPS_MAIN && !gps_done_i
      && !gps_start_i |=> rdata_o == $past(gps_sample_i[16:1], 2);
  endproperty
  a_gps_main: assert property (p_gps_main)
    else $error("gps main word wrong after load");
  property p_slot_load;
    slot_done_i[0] && ce_i ##1 rd_en && addr_i == OFS_BATTERY_VOLTAGE &&
      !slot_done_i[0] && !slot_start_i[0]
      |=> rdata_o == {1'b1, $past(slot_sample_i[14:0], 2)};
  endproperty
  a_slot_load: assert property (p_slot_load)
    else $error("slot word wrong after load");
  property p_start_clears;
    slot_start_i[0] && !slot_done_i[0] && ce_i ##1 rd_en &&
      addr_i == OFS_BATTERY_VOLTAGE && !slot_done_i[0] |=> !rdata_o[15];
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("ready flag still set after start");
  c_slot_load: cover property (slot_done_i[0] ##1 rd_en);
  c_raw_read: cover property (rd_en && addr_i == OFS_RAW_BUSY);
  c_frozen: cover property (!ce_i ##1 !ce_i);
endmodule
bind aux_result_bank aux_result_bank_asserts chk (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .slot_start_i(slot_start_i), .slot_done_i(slot_done_i),
  .slot_sample_i(slot_sample_i), .gps_start_i(gps_start_i),
  .gps_done_i(gps_done_i), .gps_sample_i(gps_sample_i),
  .modem_done_i(modem_done_i), .modem_sample_i(modem_sample_i),
  .raw_filter_i(raw_filter_i)
);
`default_nettype wire

/* verif/aux_result_bank_tb.sv */
// Purpose: Self-checking bench for the aux converter result bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Converter pulses last until the next read request
`timescale 1ns/1ps
`default_nettype none
module aux_result_bank_tb
  import aux_result_pkg::*;
;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000, modem_sample_i = 16'h0000;
  logic [15:0] rdata_o;
  logic [10:0] slot_start_i = 11'h000, slot_done_i = 11'h000;
  logic [164:0] slot_sample_i = '0;
  logic low_battery_start_i = 1'b0, low_battery_done_i = 1'b0;
  logic [11:0] low_battery_sample_i = 12'h000;
  logic gps_start_i = 1'b0, gps_done_i = 1'b0, modem_done_i = 1'b0;
  logic [16:0] gps_sample_i = 17'h00000;
  raw_filter_type raw_filter_i = '0;
  int err_total = 0, comparisons = 0;
  logic [11:0] ofs [18] = '{12'h714, 12'h716, 12'h718, 12'h71a, 12'h71c,
    12'h71e, 12'h720, 12'h722, 12'h724, 12'h726, 12'h72a, 12'h728,
    12'h72c, 12'h72e, 12'h730, 12'h732, 12'h738, 12'h73a};
  aux_result_bank DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .slot_start_i(slot_start_i),
    .slot_done_i(slot_done_i), .slot_sample_i(slot_sample_i),
    .low_battery_start_i(low_battery_start_i),
    .low_battery_done_i(low_battery_done_i),
    .low_battery_sample_i(low_battery_sample_i),
    .gps_start_i(gps_start_i), .gps_done_i(gps_done_i),
    .gps_sample_i(gps_sample_i), .modem_done_i(modem_done_i),
    .modem_sample_i(modem_sample_i), .raw_filter_i(raw_filter_i));
  always #10 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value reg %h: expected %h seen %h", addr_i, exp, seen);
    end
  endtask
  // Converter pulses drop here, so a read may follow a pulse directly
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    slot_start_i <= 11'h000;
    slot_done_i <= 11'h000;
    low_battery_start_i <= 1'b0;
    low_battery_done_i <= 1'b0;
    gps_done_i <= 1'b0;
    gps_start_i <= 1'b0;
    modem_done_i <= 1'b0;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic wr(input logic [11:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= 16'hffff;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    end_of_test();
  end
  initial begin
    logic [14:0] s;
    raw_filter_type raw_v;
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i], 16'h0000);
      wr(ofs[i]);
      rd(ofs[i], 16'h0000);
    end
    rd(12'h73c, 16'h0000);
    for (int g = 0; g < NUM_SLOTS; g++) begin
      s = 15'h2a5a ^ 15'(g);
      @(posedge clk_sys_i);
      slot_start_i[g] <= 1'b1;
      rd(ofs[g], 16'h0000);
      @(posedge clk_sys_i);
      slot_done_i[g] <= 1'b1;
      slot_sample_i[g*15+:15] <= s;
      rd(ofs[g], {1'b1, s});
      rd(ofs[g], {1'b1, s});
    end
    @(posedge clk_sys_i);
    slot_start_i[1] <= 1'b1;
    rd(ofs[1], {1'b0, 15'h2a5b});
    rd(ofs[0], {1'b1, 15'h2a5a});
    rd(ofs[6], {1'b1, 15'h2a5c});
    rd(ofs[5], {1'b1, 15'h2a5f});
    @(posedge clk_sys_i);
    low_battery_done_i <= 1'b1;
    low_battery_sample_i <= 12'habc;
    rd(OFS_LOW_BATTERY, 16'h8abc);
    @(posedge clk_sys_i);
    low_battery_start_i <= 1'b1;
    rd(OFS_LOW_BATTERY, 16'h0abc);
    // Expected words are literals: the sample is assigned by NBA here
    @(posedge clk_sys_i);
    gps_done_i <= 1'b1;
    gps_sample_i <= 17'h1b3c5;
    rd(OFS_GPS_MAIN, 16'hd9e2);
    rd(OFS_GPS_READY, 16'h8000);
    rd(OFS_GPS_EXTRA, 16'h8000);
    @(posedge clk_sys_i);
    gps_start_i <= 1'b1;
    rd(OFS_GPS_READY, 16'h0000);
    rd(OFS_GPS_MAIN, 16'hd9e2);
    @(posedge clk_sys_i);
    modem_done_i <= 1'b1;
    modem_sample_i <= 16'hbeef;
    rd(OFS_MODEM_CH7, 16'hbeef);
    for (int k = 0; k < 2; k++) begin
      raw_v = (k == 0) ? 18'h3abcd : 18'h0aa55;
      @(posedge clk_sys_i);
      raw_filter_i <= raw_v;
      rd(OFS_RAW_UPPER, raw_v.raw[16:1]);
      rd(OFS_RAW_BUSY, {{15{raw_v.busy}}, raw_v.raw[0]});
    end
    // A done pulse while disabled must not load the slot
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    slot_done_i[0] <= 1'b1;
    slot_sample_i[14:0] <= 15'h1234;
    repeat (3) @(posedge clk_sys_i);
    slot_done_i[0] <= 1'b0;
    ce_i <= 1'b1;
    rd(ofs[0], {1'b1, 15'h2a5a});
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(OFS_BATTERY_VOLTAGE, 16'h0000);
    rd(OFS_MODEM_CH7, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
